// file: rtl/ccd_pkg.sv
`default_nettype none
package ccd_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_ACC   = 8'h04;
  localparam logic [7:0] REG_STAT  = 8'h08;
  localparam logic [7:0] REG_PC    = 8'h0C;
  localparam logic [7:0] REG_PCLAT = 8'h10;
  localparam logic [7:0] REG_WDOG  = 8'h14;
  localparam logic [7:0] REG_STACK = 8'h18;
  localparam logic [7:0] REG_FADR  = 8'h1C;
  localparam logic [7:0] REG_FDAT  = 8'h20;
  // Instruction word fields
  localparam int OP_LSB   = 0;
  localparam int FA_LSB   = 3;
  localparam int DEST_BIT = 10;
  // Status fields
  localparam int ST_ZERO = 0;
  localparam int ST_TO_N = 1;
  localparam int ST_PD_N = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_SKIP = 4;
  // Stack readback field
  localparam int SP_LSB = 16;
  // Reset values
  localparam logic [2:0] STAT_RST = 3'h6;
  localparam logic [14:0] PC_RST  = 15'h0000;
  // Opcodes
  typedef enum logic [2:0] {
    OP_NOP    = 3'h0,
    OP_WDCLR  = 3'h1,
    OP_CALLA  = 3'h2,
    OP_COMPLEMENT_FILE_INSTR   = 3'h3,
    OP_CLEAR_FILE_INSTR   = 3'h4,
    OP_DECREMENT_FILE_INSTR   = 3'h5,
    OP_CLRA   = 3'h6,
    OP_DECSKZ = 3'h7
  } ccd_op_e;
  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_CALL2 = 2'b10
  } ccd_state_e;
endpackage
`default_nettype wire

// file: rtl/ccd_core.sv
// The register addresses and register access over Wishbone were chosen for this implementation.
`default_nettype none
module ccd_core #(
  parameter int STACK_DEPTH = 16,
  parameter int PRESC_BITS  = 8
) (
  input  wire logic        clk_sys,  // System clock
  input  wire logic        rstn,     // Async reset, low
  input  wire logic        wb_cyc_i, // Bus cycle
  input  wire logic        wb_stb_i, // Strobe
  input  wire logic        wb_we_i,  // Write enable
  input  wire logic [7:0]  wb_adr_i, // Byte address
  input  wire logic [3:0]  wb_sel_i, // Byte lanes
  input  wire logic [31:0] wb_dat_i, // Write data
  output logic      [31:0] wb_dat_o, // Read data
  output logic             wb_ack_o  // Acknowledge
);
  localparam int SPW = $clog2(STACK_DEPTH);

  // Byte-lane merge of a write into a word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ccd_pkg::ccd_state_e state;
  logic [7:0]            file_mem [128];
  logic [7:0]            accum;
  logic                  zero_flag;
  logic                  timeout_flag_n;
  logic                  powerdown_flag_n;
  logic                  skip_pend;
  logic [14:0]           pc;
  logic [6:0]            pc_high_latch;
  logic [7:0]            watchdog_counter;
  logic [PRESC_BITS-1:0] wd_presc;
  logic [14:0]           ret_stack [STACK_DEPTH];
  logic [SPW-1:0]        sp;
  logic [6:0]            file_ptr;

  // Bus decode
  wire        acc_go   = wb_cyc_i & wb_stb_i & wb_ack_o;
  wire        bus_wr   = acc_go & wb_we_i;
  wire        hit_ins  = wb_adr_i == ccd_pkg::REG_INSTR;
  wire        hit_acc  = wb_adr_i == ccd_pkg::REG_ACC;
  wire        hit_st   = wb_adr_i == ccd_pkg::REG_STAT;
  wire        hit_pc   = wb_adr_i == ccd_pkg::REG_PC;
  wire        hit_plat = wb_adr_i == ccd_pkg::REG_PCLAT;
  wire        hit_fadr = wb_adr_i == ccd_pkg::REG_FADR;
  wire        hit_fdat = wb_adr_i == ccd_pkg::REG_FDAT;
  wire        is_idle  = state == ccd_pkg::ST_IDLE;
  wire [31:0] wmerge_st;
  wire [31:0] wmerge_pc;

  // Instruction decode; an instruction needs both low lanes
  wire             issue   = bus_wr & hit_ins & (&wb_sel_i[1:0]) & is_idle;
  wire             exec    = issue & ~skip_pend;
  wire ccd_pkg::ccd_op_e op = ccd_pkg::ccd_op_e'(wb_dat_i[ccd_pkg::OP_LSB +: 3]);
  wire [6:0]       op_fa   = wb_dat_i[ccd_pkg::FA_LSB +: 7];
  wire             op_dest = wb_dat_i[ccd_pkg::DEST_BIT];
  wire             is_complement_file_instr = op == ccd_pkg::OP_COMPLEMENT_FILE_INSTR;
  wire             is_decrement_file_instr = op == ccd_pkg::OP_DECREMENT_FILE_INSTR;
  wire             is_dsz  = op == ccd_pkg::OP_DECSKZ;
  wire             is_clear_file_instr = op == ccd_pkg::OP_CLEAR_FILE_INSTR;
  wire             is_clra = op == ccd_pkg::OP_CLRA;
  wire             is_wdcl = op == ccd_pkg::OP_WDCLR;
  wire             is_call = op == ccd_pkg::OP_CALLA;
  wire             arith   = is_complement_file_instr | is_decrement_file_instr | is_dsz;

  // Operand and result paths
  wire [7:0] fval     = file_mem[op_fa];
  wire [7:0] res      = is_complement_file_instr ? ~fval : fval - 8'h01;
  wire       res_zero = res == 8'h00;
  wire       wr_acc   = exec & ((arith & ~op_dest) | is_clra);
  wire       wr_file  = exec & ((arith & op_dest) | is_clear_file_instr);
  wire [7:0] next_acc = is_clra ? 8'h00 : res;
  wire [7:0] next_fv  = is_clear_file_instr ? 8'h00 : res;
  wire       set_skip = exec & is_dsz & res_zero;

  // Zero flag: clears force one, complement and decrement follow result
  wire       z_upd    = exec & (is_clear_file_instr | is_clra | is_complement_file_instr | is_decrement_file_instr);
  wire       next_z   = (is_clear_file_instr | is_clra) ? 1'b1 : res_zero;

  // Watchdog timebase and clear
  wire       wd_clr   = exec & is_wdcl;
  wire       presc_wr = &wd_presc;
  wire       wd_wrap  = presc_wr & (&watchdog_counter);

  // Program counter: normal step, call push, call load
  wire [14:0] pc_inc  = pc + 15'h0001;
  wire        push    = exec & is_call;
  wire [14:0] call_pc = {pc_high_latch, accum};

  assign wmerge_st = merge({27'h0, skip_pend, 1'b0, powerdown_flag_n,
                            timeout_flag_n, zero_flag}, wb_dat_i, wb_sel_i);
  assign wmerge_pc = merge({17'h0, pc}, wb_dat_i, wb_sel_i);

  // Read mux
  wire [31:0] rd_word =
    hit_acc  ? {24'h0, accum} :
    hit_st   ? {27'h0, skip_pend, ~is_idle, powerdown_flag_n,
                timeout_flag_n, zero_flag} :
    hit_pc   ? {17'h0, pc} :
    hit_plat ? {25'h0, pc_high_latch} :
    hit_fadr ? {25'h0, file_ptr} :
    hit_fdat ? {24'h0, file_mem[file_ptr]} :
    (wb_adr_i == ccd_pkg::REG_WDOG) ?
      {{(24 - PRESC_BITS){1'b0}}, wd_presc, watchdog_counter} :
    (wb_adr_i == ccd_pkg::REG_STACK) ?
      {{(16 - SPW){1'b0}}, sp, 1'b0, ret_stack[sp - SPW'(1)]} :
    32'h0000_0000;

  // Bus handshake: ack one cycle after the strobe, then drop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_word;
    end
  end

  // Sequencer for the two-cycle call
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ccd_pkg::ST_IDLE;
    end else begin
      unique case (state)
        ccd_pkg::ST_IDLE: begin
          if (push) begin
            state <= ccd_pkg::ST_CALL2;
          end
        end
        ccd_pkg::ST_CALL2: begin
          state <= ccd_pkg::ST_IDLE;
        end
        default: begin
          state <= ccd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Program counter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pc <= ccd_pkg::PC_RST;
    end else if (state == ccd_pkg::ST_CALL2) begin
      pc <= call_pc;
    end else if (issue && !push) begin
      pc <= pc_inc;
    end else if (bus_wr && hit_pc && is_idle) begin
      pc <= wmerge_pc[14:0];
    end
  end

  // Return stack push
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sp <= '0;
    end else if (push) begin
      sp <= sp + SPW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      ret_stack[sp] <= pc_inc;
    end
  end

  // Accumulator and high latch
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      accum         <= 8'h00;
      pc_high_latch <= 7'h00;
    end else begin
      if (wr_acc) begin
        accum <= next_acc;
      end else if (bus_wr && hit_acc && wb_sel_i[0]) begin
        accum <= wb_dat_i[7:0];
      end
      if (bus_wr && hit_plat && wb_sel_i[0]) begin
        pc_high_latch <= wb_dat_i[6:0];
      end
    end
  end

  // File register array and its window pointer
  always_ff @(posedge clk_sys) begin
    if (wr_file) begin
      file_mem[op_fa] <= next_fv;
    end else if (bus_wr && hit_fdat && wb_sel_i[0]) begin
      file_mem[file_ptr] <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      file_ptr <= 7'h00;
    end else if (bus_wr && hit_fadr && wb_sel_i[0]) begin
      file_ptr <= wb_dat_i[6:0];
    end
  end

  // Status flags; an instruction wins over a bus write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {powerdown_flag_n, timeout_flag_n, zero_flag} <= ccd_pkg::STAT_RST;
      skip_pend <= 1'b0;
    end else begin
      if (z_upd) begin
        zero_flag <= next_z;
      end else if (bus_wr && hit_st) begin
        zero_flag <= wmerge_st[ccd_pkg::ST_ZERO];
      end
      if (wd_wrap) begin
        timeout_flag_n <= 1'b0;
      end else if (wd_clr) begin
        timeout_flag_n <= 1'b1;
      end else if (bus_wr && hit_st) begin
        timeout_flag_n <= wmerge_st[ccd_pkg::ST_TO_N];
      end
      if (wd_clr) begin
        powerdown_flag_n <= 1'b1;
      end else if (bus_wr && hit_st) begin
        powerdown_flag_n <= wmerge_st[ccd_pkg::ST_PD_N];
      end
      if (issue) begin
        skip_pend <= set_skip;
      end
    end
  end

  // Watchdog counter and prescaler
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      watchdog_counter <= 8'h00;
      wd_presc         <= '0;
    end else if (wd_clr) begin
      watchdog_counter <= 8'h00;
      wd_presc         <= '0;
    end else begin
      wd_presc <= wd_presc + PRESC_BITS'(1);
      if (presc_wr) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_call_issue;
    push ##1 (state == ccd_pkg::ST_CALL2);
  endsequence

  a_wdog_clear: assert property (wd_clr |=> watchdog_counter == 8'h00)
    else $error("watchdog counter not cleared");
  a_presc_clear: assert property (wd_clr |=> wd_presc == '0)
    else $error("prescaler not cleared");
  a_wdog_flags: assert property (wd_clr && !wd_wrap |=>
      timeout_flag_n && powerdown_flag_n && $stable(zero_flag))
    else $error("watchdog clear flags wrong");
  a_call_push: assert property (push |=>
      ret_stack[$past(sp)] == $past(pc) + 15'h0001)
    else $error("return address not pushed");
  a_call_load: assert property (s_call_issue |=>
      pc == {$past(pc_high_latch, 2), $past(accum, 2)} && is_idle)
    else $error("call target wrong");
  a_call_flags: assert property (push |=> ##1
      $stable(zero_flag) && $stable(timeout_flag_n))
    else $error("call changed flags");
  a_clear_file_instr_zero: assert property (exec && is_clear_file_instr |=>
      zero_flag && file_mem[$past(op_fa)] == 8'h00)
    else $error("file clear wrong");
  a_clra_zero: assert property (exec && is_clra |=>
      zero_flag && accum == 8'h00)
    else $error("accumulator clear wrong");
  a_complement_file_instr_result: assert property (exec && is_complement_file_instr && !op_dest |=>
      accum == ~$past(fval))
    else $error("complement result wrong");
  a_decrement_file_instr_result: assert property (exec && is_decrement_file_instr && op_dest |=>
      file_mem[$past(op_fa)] == $past(fval) - 8'h01)
    else $error("decrement result wrong");
  a_dsz_noflag: assert property (exec && is_dsz |=> $stable(zero_flag))
    else $error("skip decrement changed flag");
  a_skip_set: assert property (set_skip |=> skip_pend)
    else $error("skip not armed on zero result");
  a_skip_nop: assert property (skip_pend && issue |=>
      $stable(accum) && $stable(zero_flag) && !skip_pend)
    else $error("skipped instruction took effect");
  a_zero_track: assert property (exec && (is_complement_file_instr || is_decrement_file_instr) |=>
      zero_flag == ($past(res) == 8'h00))
    else $error("zero flag not tracking result");
endmodule
`default_nettype wire

// file: verif/tb_clear_complement_decrement_ops.sv
`default_nettype none
module tb_clear_complement_decrement_ops;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t ns: got %h expected %h", $time, (got), (exp)); end end

  logic        clk_sys  = 1'b0;  // System clock
  logic        rstn     = 1'b0;  // Reset, low
  logic        wb_cyc_i = 1'b0;  // Bus cycle
  logic        wb_stb_i = 1'b0;  // Strobe
  logic        wb_we_i  = 1'b0;  // Write enable
  logic [7:0]  wb_adr_i = 8'h00; // Address
  logic [3:0]  wb_sel_i = 4'hF;  // Byte lanes
  logic [31:0] wb_dat_i = '0;    // Write data
  logic [31:0] wb_dat_o;         // Read data
  logic        wb_ack_o;         // Acknowledge
  logic [31:0] exp_q[$];         // Expected read values
  logic [31:0] msk_q[$];         // Bits that matter
  logic [31:0] got_v;            // Masked read data
  logic [31:0] exp_v;            // Oldest expectation
  int          err_count = 0;
  int          cmp_count = 0;
  int          seed      = 32'hcd51;
  int          sp        = 0;
  logic [7:0]  v, a, r;
  logic [6:0]  fa, lat;
  logic [14:0] pc;
  logic        z;

  ccd_core #(.STACK_DEPTH(16), .PRESC_BITS(8)) DUT (
    .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

  // Clock, 100 ns period
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  // One classic cycle, held until ack
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_count++;
      $display("wrong value at %0t ns: got ack 0 expected 1", $time);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat);
  endtask

  // Read, noting the expectation first
  task automatic rd(input logic [7:0] adr, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, adr, $random(seed));
  endtask

  task automatic exec(input logic [2:0] op, input logic [6:0] f, input logic d);
    wr(ccd_pkg::REG_INSTR, {21'h0, d, f, op});
  endtask

  task automatic set_file(input logic [6:0] f, input logic [7:0] val);
    wr(ccd_pkg::REG_FADR, {25'h0, f});
    wr(ccd_pkg::REG_FDAT, {24'h0, val});
  endtask

  // Read-data checker, oldest note first
  always @(posedge clk_sys) begin
    if (wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_count++;
      end else begin
        exp_v = exp_q.pop_front();
        got_v = wb_dat_o & msk_q.pop_front();
        `CHK(got_v, exp_v)
      end
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog against hangs
  initial begin
    #(8000 * 100);
    err_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      fa = 7'($random(seed));
      v = (i == 2) ? 8'hFF : (i == 7) ? 8'h01 : 8'($random(seed));
      set_file(fa, v);
      exec(i < 4 ? ccd_pkg::OP_COMPLEMENT_FILE_INSTR : ccd_pkg::OP_DECREMENT_FILE_INSTR, fa, i[0]);
      r = (i < 4) ? ~v : v - 8'h01;
      if (i[0]) begin
        rd(ccd_pkg::REG_FDAT, {24'h0, r}, 32'hFF);
      end else begin
        rd(ccd_pkg::REG_ACC, {24'h0, r}, 32'hFF);
      end
      rd(ccd_pkg::REG_STAT, {31'h0, r == 8'h00}, 32'h1);
    end
    $display("test complement and decrement done");
    set_file(fa, v | 8'h01);
    wr(ccd_pkg::REG_STAT, 32'h6);
    exec(ccd_pkg::OP_CLEAR_FILE_INSTR, fa, 1'b0);
    rd(ccd_pkg::REG_FDAT, 32'h0, 32'hFF);
    rd(ccd_pkg::REG_STAT, 32'h1, 32'h1);
    wr(ccd_pkg::REG_ACC, {24'h0, v | 8'h01});
    wr(ccd_pkg::REG_STAT, 32'h6);
    exec(ccd_pkg::OP_CLRA, 7'h00, 1'b0);
    rd(ccd_pkg::REG_ACC, 32'h0, 32'hFF);
    rd(ccd_pkg::REG_STAT, 32'h1, 32'h1);
    $display("test clears done");
    z = 1'($random(seed));
    wr(ccd_pkg::REG_STAT, {29'h0, 2'b11, z});
    wr(ccd_pkg::REG_PC, 32'h0100);
    set_file(fa, 8'h01);
    exec(ccd_pkg::OP_DECSKZ, fa, 1'b1);
    rd(ccd_pkg::REG_FDAT, 32'h0, 32'hFF);
    rd(ccd_pkg::REG_STAT, {27'h0, 2'b10, 2'b11, z}, 32'h1F);
    rd(ccd_pkg::REG_PC, 32'h0101, 32'h7FFF);
    wr(ccd_pkg::REG_ACC, 32'h5A);
    exec(ccd_pkg::OP_CLRA, 7'h00, 1'b0);
    rd(ccd_pkg::REG_ACC, 32'h5A, 32'hFF);
    rd(ccd_pkg::REG_STAT, {29'h0, 2'b11, z}, 32'h1F);
    set_file(fa, 8'h05);
    exec(ccd_pkg::OP_DECSKZ, fa, 1'b0);
    rd(ccd_pkg::REG_ACC, 32'h04, 32'hFF);
    exec(ccd_pkg::OP_CLRA, 7'h00, 1'b0);
    rd(ccd_pkg::REG_ACC, 32'h0, 32'hFF);
    $display("test decrement skip done");
    for (int i = 0; i < 2; i++) begin
      a = 8'($random(seed));
      lat = 7'($random(seed));
      pc = 15'($random(seed));
      z = 1'($random(seed));
      wr(ccd_pkg::REG_ACC, {24'h0, a});
      wr(ccd_pkg::REG_PCLAT, {25'h0, lat});
      wr(ccd_pkg::REG_PC, {17'h0, pc});
      wr(ccd_pkg::REG_STAT, {29'h0, 2'b11, z});
      exec(ccd_pkg::OP_CALLA, 7'h00, 1'b0);
      sp++;
      rd(ccd_pkg::REG_STACK, {12'h0, 4'(sp), 1'b0, pc + 15'h1}, 32'h000F7FFF);
      rd(ccd_pkg::REG_PC, {17'h0, lat, a}, 32'h7FFF);
      rd(ccd_pkg::REG_STAT, {29'h0, 2'b11, z}, 32'h1F);
    end
    exec(ccd_pkg::OP_NOP, 7'h00, 1'b0);
    rd(ccd_pkg::REG_PC, {17'h0, {lat, a} + 15'h1}, 32'h7FFF);
    $display("test call through accumulator done");
    wr(ccd_pkg::REG_STAT, 32'h0);
    repeat (700) @(posedge clk_sys);
    exec(ccd_pkg::OP_WDCLR, 7'h00, 1'b0);
    rd(ccd_pkg::REG_WDOG, 32'h0, 32'h0000F8FF);
    rd(ccd_pkg::REG_STAT, 32'h6, 32'h1F);
    rd(8'hFC, 32'h0, 32'hFFFFFFFF);
    $display("test watchdog clear done");
    @(posedge clk_sys);
    wrap_up();
  end
endmodule
`default_nettype wire
